// ### shared/raf_pkg.sv
/*
 Package for the receive address filter register block: offsets, field
 positions, reset values and CRC constants.
 Assumes byte addresses on a plain 8-bit register port with 32-bit data.
*/
package raf_pkg;
    localparam int unsigned RAF_AW = 8;
    localparam logic [7:0] RAF_OFS_STA_LOW = 8'hA4;
    localparam logic [7:0] RAF_OFS_STA_HIGH = 8'hA8;
    localparam logic [7:0] RAF_OFS_GRP_LOW = 8'hAC;
    localparam logic [7:0] RAF_OFS_GRP_HIGH = 8'hB0;
    localparam logic [7:0] RAF_OFS_IND_LOW = 8'hB4;
    localparam logic [7:0] RAF_OFS_IND_HIGH = 8'hB8;
    localparam logic [7:0] RAF_OFS_MODE = 8'hFC;
    // Mode register fields
    localparam int unsigned RAF_BIT_SPEED = 31;
    localparam int unsigned RAF_BIT_DUPLEX = 30;
    localparam int unsigned RAF_BIT_LINK = 29;
    localparam int unsigned RAF_BIT_RELOAD = 26;
    localparam logic [2:0] RAF_MODE_SINGLE = 3'h7;
    localparam logic [2:0] RAF_MODE_MAC_ONLY = 3'h4;
    localparam logic [2:0] RAF_RX_STOPPED = 3'h0;
    localparam logic [31:0] RAF_HASH_RESET = 32'h0000_0000;
    localparam logic [47:0] RAF_STA_RESET = 48'h0000_0000_0000;
    // CRC-32 in reflected form, seed all ones
    localparam logic [31:0] RAF_CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] RAF_CRC_SEED = 32'hFFFF_FFFF;
endpackage

// ### logic/raf_hash_lookup.sv
/*
 Hash lookup: CRC-32 over a 48-bit destination address and selection of one
 bit of a 64-bit table. Purely combinational.
 Assumes the address arrives in wire order, byte 0 in bits 7:0.
*/
`timescale 1ns/1ps
module raf_hash_lookup
    import raf_pkg::*;
(
    input wire logic [47:0] dest_addr,
    input wire logic [31:0] table_low,
    input wire logic [31:0] table_high,
    output logic [5:0] hash_index,
    output logic hash_hit
);
    ////////////////////////////////////////////////////////////////////////
    // CRC over the six address bytes, least significant bit first
    function automatic logic [31:0] raf_crc48(input logic [47:0] d);
        logic [31:0] c;
        c = RAF_CRC_SEED;
        for (int i = 0; i < 48; i++)
        begin
            if (c[0] ^ d[i])
                c = (c >> 1) ^ RAF_CRC_POLY;
            else
                c = c >> 1;
        end
        return c;
    endfunction

    logic [31:0] crc;

    // Low six bits pick the entry; bit 5 picks the word, 4:0 the bit
    always_comb
    begin
        crc = raf_crc48(dest_addr);
        hash_index = crc[5:0];
        if (crc[5])
            hash_hit = table_high[crc[4:0]];
        else
            hash_hit = table_low[crc[4:0]];
    end
endmodule

// ### logic/raf_regs.sv
/*
 Receive address filter and operating mode registers.
 Holds the six-byte station address, the group and the individual hash
 tables of 64 bits each, and the operating mode register with its link
 status bits, its reload request and its mode field. Answers the hash
 lookup for the destination address of the frame being filtered, for both
 tables at once.
 Read data are zero in every cycle but the one after a read strobe, so an
 idle port shows zero.
 Assumes a plain register port (address, write data, write and read strobe,
 read data one cycle later), the receive state from the receive process, a
 configuration-memory reader that supplies the station address, and link
 status from the PHY side, all synchronous to clk.
 Assumes that software stops the receiver before it rewrites the station
 address or the group table; a write made while the receiver runs completes
 on the bus and changes nothing.
 Assumes that the configuration-memory reader pulses cfg_load_valid once for
 each load and cfg_reload_done once when a requested reload has finished,
 and that it starts a reload on the cfg_reload_start pulse.
 Assumes that whoever uses the filter decisions samples them while the
 destination address stands; they are not registered here.
*/
// Design decision made here: the address-and-strobe port.
// Contract
// - Station address loads from configuration memory, not from fixed constants.
// - Low register bytes 0..3 ascending; high register bytes 4,5; rest reserved.
// - Station address always readable; writes only while receive state is stopped.
// - Multicast hash always readable; writes only while receive state is stopped.
// - CRC-32 over destination address; low six bits select one of 64.
// - CRC bit 5 selects upper or lower hash word.
// - CRC bits 4:0 select bit within the chosen word.
// - Multicast hash low holds bits 31:0, high 63:32, reset zero.
// - Unicast hash uses two words, reset zero, same CRC selection.
// - Mode bit 31 reads speed, 1 means 100 Mb/s, reset zero.
// - Mode bit 30 reads duplex, 1 means full, reset zero.
// - Writing 1 to bit 26 starts reload; clears when reload finishes.
// - Mode field bits 2:0 resets to 111b, single chip with internal PHY.
`timescale 1ns/1ps
module raf_regs
    import raf_pkg::*;
#(
    parameter int unsigned ADDR_W = RAF_AW
)
(
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Receive process state field of the process status word
    input wire logic [2:0] rx_state,
    // Configuration memory reader
    input wire logic cfg_load_valid,
    input wire logic [47:0] cfg_station_addr,
    input wire logic cfg_reload_done,
    output logic cfg_reload_start,
    // Link status from the PHY side
    input wire logic phy_speed_100,
    input wire logic phy_full_duplex,
    input wire logic phy_link_up,
    // Frame being filtered
    input wire logic [47:0] frame_dest_addr,
    output logic group_pass,
    output logic individual_pass,
    output logic [5:0] frame_hash_index,
    // Operating mode and station address outputs
    output logic [2:0] operating_mode_field,
    output logic mac_only_mode,
    output logic diag_mode,
    output logic [47:0] station_address
);
    ////////////////////////////////////////////////////////////////////////
    // State

    // Every register of the block in one record; the next-state process fills a
    // copy of it and the state register loads the copy on each edge
    typedef struct packed {
        logic [47:0] station;
        logic [31:0] grp_low;
        logic [31:0] grp_high;
        logic [31:0] ind_low;
        logic [31:0] ind_high;
        logic speed;
        logic duplex;
        logic link;
        logic reload;
        logic reload_start;
        logic [2:0] mode;
        logic [31:0] rdata;
    } raf_state_s;

    raf_state_s state_reg;
    raf_state_s state_next;

    // Receive-state gate and per-register write strobes
    logic rx_stopped;
    logic wr_sta_low;
    logic wr_sta_high;
    logic wr_grp_low;
    logic wr_grp_high;
    logic wr_ind_low;
    logic wr_ind_high;
    logic wr_mode;

    // Results of the two table lookups
    logic grp_hit;
    logic ind_hit;
    logic [5:0] grp_index;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Full-width offset compare, shared by the write strobes and the read multiplexer
    function automatic logic raf_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Mode register image; reserved bits 28:27 and 25:3 read zero
    function automatic logic [31:0] raf_mode_word(
        input logic speed,
        input logic duplex,
        input logic link,
        input logic reload,
        input logic [2:0] mode
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[RAF_BIT_SPEED] = speed;
        w[RAF_BIT_DUPLEX] = duplex;
        w[RAF_BIT_LINK] = link;
        w[RAF_BIT_RELOAD] = reload;
        w[2:0] = mode;
        return w;
    endfunction

    // Write strobes per register
    // The receive-state gate is applied where the registers load, not here
    assign rx_stopped = (rx_state == RAF_RX_STOPPED);
    assign wr_sta_low = reg_write && raf_hit(reg_addr, RAF_OFS_STA_LOW);
    assign wr_sta_high = reg_write && raf_hit(reg_addr, RAF_OFS_STA_HIGH);
    assign wr_grp_low = reg_write && raf_hit(reg_addr, RAF_OFS_GRP_LOW);
    assign wr_grp_high = reg_write && raf_hit(reg_addr, RAF_OFS_GRP_HIGH);
    assign wr_ind_low = reg_write && raf_hit(reg_addr, RAF_OFS_IND_LOW);
    assign wr_ind_high = reg_write && raf_hit(reg_addr, RAF_OFS_IND_HIGH);
    assign wr_mode = reg_write && raf_hit(reg_addr, RAF_OFS_MODE);

    ////////////////////////////////////////////////////////////////////////
    // Hash lookups, one per table

    // Both lookups run the same CRC over the same address, so only the group
    // lookup's index is brought out; the individual one is left open
    raf_hash_lookup u_group
    (
        .dest_addr(frame_dest_addr),
        .table_low(state_reg.grp_low),
        .table_high(state_reg.grp_high),
        .hash_index(grp_index),
        .hash_hit(grp_hit)
    );

    raf_hash_lookup u_individual
    (
        .dest_addr(frame_dest_addr),
        .table_low(state_reg.ind_low),
        .table_high(state_reg.ind_high),
        .hash_index(),
        .hash_hit(ind_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        // Hold every register unless a case below changes it; the start is a pulse
        state_next = state_reg;
        state_next.reload_start = 1'b0;

        // Status sampled every cycle
        // The PHY side runs on clk, so one register stage is the whole delay
        state_next.speed = phy_speed_100;
        state_next.duplex = phy_full_duplex;
        state_next.link = phy_link_up;

        // Station address, software writes gated by stopped receiver
        // The receive process compares frames against it while running, so a write
        // made then completes on the bus and is simply dropped
        if (wr_sta_low && rx_stopped)
        begin
            state_next.station[31:0] = reg_wdata;
        end
        if (wr_sta_high && rx_stopped)
        begin
            state_next.station[47:32] = reg_wdata[15:0];
        end
        // Memory load wins over a software write in the same cycle
        if (cfg_load_valid)
        begin
            state_next.station = cfg_station_addr;
        end

        // Multicast hash table, writes gated by stopped receiver
        // The receive process reads this table while running; same gate as above
        if (wr_grp_low && rx_stopped)
        begin
            state_next.grp_low = reg_wdata;
        end
        if (wr_grp_high && rx_stopped)
        begin
            state_next.grp_high = reg_wdata;
        end

        // Unicast hash table
        // Not gated: the individual table may be rewritten while frames arrive
        if (wr_ind_low)
        begin
            state_next.ind_low = reg_wdata;
        end
        if (wr_ind_high)
        begin
            state_next.ind_high = reg_wdata;
        end

        // Mode register: field and reload request
        // A request made while a reload runs is dropped, so the reader never sees a
        // second start in the middle of its transfer; the flag stays set until done
        if (wr_mode)
        begin
            // Any code is stored; codes other than the two normal ones select diagnostics
            state_next.mode = reg_wdata[2:0];
            if (reg_wdata[RAF_BIT_RELOAD] && !state_reg.reload)
            begin
                state_next.reload = 1'b1;
                state_next.reload_start = 1'b1;
            end
        end
        // Reload bit clears itself when the reader reports completion
        if (cfg_reload_done && state_reg.reload)
        begin
            state_next.reload = 1'b0;
        end

        // Read data, registered so that it stands only in the cycle after the strobe;
        // unmapped offsets and idle cycles read zero
        state_next.rdata = 32'h0000_0000;
        if (reg_read)
        begin
            unique case (1'b1)
                raf_hit(reg_addr, RAF_OFS_STA_LOW):
                begin
                    state_next.rdata = state_reg.station[31:0];
                end
                raf_hit(reg_addr, RAF_OFS_STA_HIGH):
                begin
                    // Reserved upper half reads zero
                    state_next.rdata = {16'h0000, state_reg.station[47:32]};
                end
                raf_hit(reg_addr, RAF_OFS_GRP_LOW):
                begin
                    state_next.rdata = state_reg.grp_low;
                end
                raf_hit(reg_addr, RAF_OFS_GRP_HIGH):
                begin
                    state_next.rdata = state_reg.grp_high;
                end
                raf_hit(reg_addr, RAF_OFS_IND_LOW):
                begin
                    state_next.rdata = state_reg.ind_low;
                end
                raf_hit(reg_addr, RAF_OFS_IND_HIGH):
                begin
                    state_next.rdata = state_reg.ind_high;
                end
                raf_hit(reg_addr, RAF_OFS_MODE):
                begin
                    // Status bits are read-only; a write to them is dropped
                    state_next.rdata = raf_mode_word(state_reg.speed, state_reg.duplex,
                        state_reg.link, state_reg.reload, state_reg.mode);
                end
                default:
                begin
                    // Unmapped offset
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Asynchronous reset loads constants only, so no input reaches a flop
    // through the reset branch
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // Station address stays zero until the first load or a software write while stopped
            state_reg.station <= RAF_STA_RESET;
            // Both hash tables empty
            state_reg.grp_low <= RAF_HASH_RESET;
            state_reg.grp_high <= RAF_HASH_RESET;
            state_reg.ind_low <= RAF_HASH_RESET;
            state_reg.ind_high <= RAF_HASH_RESET;
            // Status clear, no reload pending, single-chip mode
            state_reg.speed <= 1'b0;
            state_reg.duplex <= 1'b0;
            state_reg.link <= 1'b0;
            state_reg.reload <= 1'b0;
            state_reg.reload_start <= 1'b0;
            state_reg.mode <= RAF_MODE_SINGLE;
            state_reg.rdata <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Register-driven data
    assign reg_rdata = state_reg.rdata;
    assign cfg_reload_start = state_reg.reload_start;
    assign station_address = state_reg.station;
    assign operating_mode_field = state_reg.mode;

    // Mode decode for the pin multiplexer and the diagnostic paths
    assign mac_only_mode = (state_reg.mode == RAF_MODE_MAC_ONLY);
    assign diag_mode = !mac_only_mode && (state_reg.mode != RAF_MODE_SINGLE);

    // Filter decisions follow the tables and the frame address with no register;
    // the index is the group lookup's, identical for both tables
    assign group_pass = grp_hit;
    assign individual_pass = ind_hit;
    assign frame_hash_index = grp_index;
endmodule

// ### bench/raf_regs_sva.sv
/*
 Checker for the receive address filter registers.
 Assumes it is bound to raf_regs and sees only its ports.
*/
`timescale 1ns/1ps
module raf_regs_sva
    import raf_pkg::*;
#(
    parameter int unsigned ADDR_W = RAF_AW
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0] rx_state,
    input wire logic cfg_load_valid,
    input wire logic [47:0] cfg_station_addr,
    input wire logic cfg_reload_start,
    input wire logic phy_speed_100,
    input wire logic phy_full_duplex,
    input wire logic phy_link_up,
    input wire logic [2:0] operating_mode_field,
    input wire logic mac_only_mode,
    input wire logic diag_mode,
    input wire logic [47:0] station_address
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Station address and read port
    chk_station_blocked: assert property (
        reg_write && rx_state != RAF_RX_STOPPED && !cfg_load_valid &&
        (reg_addr == RAF_OFS_STA_LOW || reg_addr == RAF_OFS_STA_HIGH)
        |=> $stable(station_address)) else $error("station address changed while running");
    chk_station_load: assert property (
        cfg_load_valid |=> station_address == $past(cfg_station_addr))
        else $error("station address not loaded");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    chk_high_reserved: assert property (
        reg_read && reg_addr == RAF_OFS_STA_HIGH |=> reg_rdata[31:16] == 16'h0)
        else $error("reserved station bits not zero");
    ////////////////////////////////////////////////////////////////////////////////
    // Mode register
    chk_status_bits: assert property (
        reg_read && reg_addr == RAF_OFS_MODE && $past(resetn) |=> reg_rdata[31:29] ==
        $past({phy_speed_100, phy_full_duplex, phy_link_up}, 2))
        else $error("status bits wrong");
    chk_reload_cause: assert property ($rose(cfg_reload_start) |->
        $past(reg_write) && $past(reg_addr) == RAF_OFS_MODE && $past(reg_wdata[26]))
        else $error("reload start without request");
    chk_reload_pulse: assert property (cfg_reload_start |=> !cfg_reload_start)
        else $error("reload start too long");
    chk_mode_write: assert property (
        reg_write && reg_addr == RAF_OFS_MODE |=> operating_mode_field == $past(reg_wdata[2:0]))
        else $error("mode field not written");
    chk_mac_only: assert property (
        mac_only_mode == (operating_mode_field == RAF_MODE_MAC_ONLY))
        else $error("mac only decode wrong");
    chk_diag_decode: assert property (
        diag_mode == (operating_mode_field != RAF_MODE_SINGLE &&
        operating_mode_field != RAF_MODE_MAC_ONLY)) else $error("diag decode wrong");
endmodule
bind raf_regs raf_regs_sva #(.ADDR_W(ADDR_W)) u_raf_regs_sva (.clk, .resetn, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_state, .cfg_load_valid,
    .cfg_station_addr, .cfg_reload_start, .phy_speed_100, .phy_full_duplex, .phy_link_up,
    .operating_mode_field, .mac_only_mode, .diag_mode, .station_address);

// ### bench/testbench.sv
/*
 Self-checking bench for raf_regs with a register and CRC model.
 Assumes one 100 MHz clock; the bench drives every design input.
*/
`timescale 1ns/1ps
module testbench
    import raf_pkg::*;
;
    logic clk, resetn, reg_write, reg_read, cfg_load_valid, cfg_reload_done, cfg_reload_start;
    logic phy_speed_100, phy_full_duplex, phy_link_up, group_pass, individual_pass;
    logic mac_only_mode, diag_mode;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, crc;
    logic [2:0] rx_state, operating_mode_field;
    logic [5:0] frame_hash_index;
    logic [47:0] cfg_station_addr, frame_dest_addr, station_address;
    logic [31:0] mdl [logic [7:0]];
    logic [7:0] offs [8] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hFC, 8'hC0};
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 59;
    raf_regs u_raf_regs (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .rx_state, .cfg_load_valid, .cfg_station_addr, .cfg_reload_done,
        .cfg_reload_start, .phy_speed_100, .phy_full_duplex, .phy_link_up, .frame_dest_addr,
        .group_pass, .individual_pass, .frame_hash_index, .operating_mode_field,
        .mac_only_mode, .diag_mode, .station_address);
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog, checks and bus cycles
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000 n_mismatch++;
        end_sim;
    end
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cmp(input string name, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [31:0] crc_of(input logic [47:0] d);
        logic [31:0] c;
        c = RAF_CRC_SEED;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? RAF_CRC_POLY : 32'h0);
        return c;
    endfunction
    // Model write: group hash and station gated by receive state, individual hash not, mode keeps a set reload bit
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        if (a == RAF_OFS_MODE)
            mdl[a] = (mdl[a] & 32'h0400_0000) | (d & 32'h0400_0007);
        else if (mdl.exists(a) && (rx_state == RAF_RX_STOPPED || a >= RAF_OFS_IND_LOW))
            mdl[a] = (a == RAF_OFS_STA_HIGH) ? (d & 32'h0000_FFFF) : d;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 cmp("rdata", !mdl.exists(a) ? 48'h0 : (a != RAF_OFS_MODE) ? 48'(mdl[a]) :
            48'(mdl[a] | {phy_speed_100, phy_full_duplex, phy_link_up, 29'h0}), reg_rdata);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {resetn, reg_write, reg_read, cfg_load_valid, cfg_reload_done} = 5'h0;
        {phy_speed_100, phy_full_duplex, phy_link_up, rx_state} = 6'h0;
        {reg_addr, reg_wdata, cfg_station_addr, frame_dest_addr} = 136'h0;
        for (int i = 0; i < 6; i++)
            mdl[offs[i]] = 32'h0;
        mdl[RAF_OFS_MODE] = 32'h7;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(offs[i]);
        // Station address from configuration memory
        @(posedge clk);
        cfg_station_addr <= {16'($random(seed)), 32'($random(seed))};
        cfg_load_valid <= 1'b1;
        @(posedge clk);
        cfg_load_valid <= 1'b0;
        mdl[RAF_OFS_STA_LOW] = cfg_station_addr[31:0];
        mdl[RAF_OFS_STA_HIGH] = {16'h0, cfg_station_addr[47:32]};
        #1 cmp("station", cfg_station_addr, station_address);
        // Writes while stopped, then while running
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk);
            rx_state <= (p == 0) ? RAF_RX_STOPPED : (3'($random(seed)) | 3'h1);
            for (int i = 0; i < 8; i++)
                wr(offs[i], (i == 6) ? 32'h7 : 32'($random(seed)));
            for (int i = 0; i < 8; i++)
                rd(offs[i]);
            cmp("station", {mdl[RAF_OFS_STA_HIGH][15:0], mdl[RAF_OFS_STA_LOW]},
                station_address);
        end
        // Hash lookup against random tables
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clk);
            frame_dest_addr <= {16'($random(seed)), 32'($random(seed))};
            #1 crc = crc_of(frame_dest_addr);
            cmp("index", crc[5:0], frame_hash_index);
            cmp("group", mdl[crc[5] ? RAF_OFS_GRP_HIGH : RAF_OFS_GRP_LOW][crc[4:0]],
                group_pass);
            cmp("individual", mdl[crc[5] ? RAF_OFS_IND_HIGH : RAF_OFS_IND_LOW][crc[4:0]],
                individual_pass);
        end
        // Every mode code
        for (int m = 0; m < 8; m++)
        begin
            wr(RAF_OFS_MODE, 32'(m));
            cmp("mac_only", (m == 4), mac_only_mode);
            cmp("diag", (m != 4 && m != 7), diag_mode);
            rd(RAF_OFS_MODE);
        end
        // Reload start, refused repeat, completion
        wr(RAF_OFS_MODE, 32'h0400_0007);
        cmp("reload_start", 1'b1, cfg_reload_start);
        rd(RAF_OFS_MODE);
        wr(RAF_OFS_MODE, 32'h0400_0007);
        cmp("reload_start", 1'b0, cfg_reload_start);
        @(posedge clk);
        cfg_reload_done <= 1'b1;
        @(posedge clk);
        cfg_reload_done <= 1'b0;
        mdl[RAF_OFS_MODE][26] = 1'b0;
        rd(RAF_OFS_MODE);
        // Link status bits
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            {phy_speed_100, phy_full_duplex, phy_link_up} <= 3'($random(seed));
            repeat (2) @(posedge clk);
            rd(RAF_OFS_MODE);
        end
        // Reset in mid-run clears the filled tables and restores the mode field
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            mdl[offs[i]] = 32'h0;
        mdl[RAF_OFS_MODE] = 32'h7;
        #1 cmp("mode", RAF_MODE_SINGLE, operating_mode_field);
        cmp("group", 1'b0, group_pass);
        cmp("individual", 1'b0, individual_pass);
        for (int i = 0; i < 8; i++)
            rd(offs[i]);
        end_sim;
    end
endmodule
